// [rtl/sleep_mode_controller.sv]
// Sleep mode controller with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Sleep needs allow bit plus halt instruction
// - Mode 000 Idle stops core, flash clocks
// - Idle wakes on external and internal interrupts
// - Comparator off bit powers comparator down
// - Mode 001 stops I/O, core, flash clocks
// - ADC quiet keeps ADC, async, LCD running
// - Idle/ADC quiet entry starts enabled ADC
// - ADC quiet wakes on listed sources only
// - Non-idle modes take only level irq zero
// - Timer oscillator only with async LCD/timer
// - Interrupt wake holds core four cycles
// - Register file and SRAM kept across sleep
// - Reset during sleep restarts at vector
// - Brown-out sleep-off bit 6, reset 0
// - Sleep-off write needs timed enable sequence
// - Sleep-off cuts detector in deep modes
// - Any wake re-enables the brown-out detector
// - Detector cut stretches wake to 60 us
// - Power-down 010, save 011, standby 110
// - Standby wakes within six cycles
module sleep_mode_controller #(
   parameter int STARTUP_CYCLES = 16,
   parameter int WAKE_W = sleep_ctrl_pkg::WAKE_COUNT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic halt_instr,
   input wire logic [WAKE_W-1:0] wake_src,
   input wire logic reset_request,
   output logic core_hold,
   output logic resume_from_reset,
   output logic clk_cpu_en,
   output logic clk_flash_en,
   output logic clk_io_en,
   output logic clk_adc_en,
   output logic clk_async_en,
   output logic main_osc_en,
   output logic timer_osc_en,
   output logic brownout_en,
   output logic comparator_power,
   output logic adc_start
);
   localparam int DW = sleep_ctrl_pkg::DELAY_W;

   generate
      if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << DW)) begin : g_bad_startup
         $error("STARTUP_CYCLES out of range");
      end
      if (WAKE_W != sleep_ctrl_pkg::WAKE_COUNT) begin : g_bad_wake
         $error("WAKE_W must match wake source count");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   function automatic logic mode_valid(input logic [2:0] m);
      return m == sleep_ctrl_pkg::MODE_IDLE || m == sleep_ctrl_pkg::MODE_ADC_QUIET ||
         m == sleep_ctrl_pkg::MODE_POWER_DOWN || m == sleep_ctrl_pkg::MODE_POWER_SAVE ||
         m == sleep_ctrl_pkg::MODE_STANDBY;
   endfunction

   function automatic logic deep_mode(input logic [2:0] m);
      return m == sleep_ctrl_pkg::MODE_POWER_DOWN || m == sleep_ctrl_pkg::MODE_POWER_SAVE ||
         m == sleep_ctrl_pkg::MODE_STANDBY;
   endfunction

   function automatic logic [WAKE_W-1:0] wake_mask(input logic [2:0] m, input logic cmp_off_in);
      logic [WAKE_W-1:0] k;
      k = '0;
      if (m == sleep_ctrl_pkg::MODE_IDLE) begin
         k = '1;
         k[sleep_ctrl_pkg::WAKE_COMPARATOR] = ~cmp_off_in;
      end else if (mode_valid(m)) begin
         k[sleep_ctrl_pkg::WAKE_IRQ0_LEVEL] = 1'b1;
         k[sleep_ctrl_pkg::WAKE_PIN_CHANGE] = 1'b1;
         k[sleep_ctrl_pkg::WAKE_SERIAL_START] = 1'b1;
         k[sleep_ctrl_pkg::WAKE_WATCHDOG] = 1'b1;
         if (m == sleep_ctrl_pkg::MODE_ADC_QUIET || m == sleep_ctrl_pkg::MODE_POWER_SAVE) begin
            k[sleep_ctrl_pkg::WAKE_ASYNC_TIMER] = 1'b1;
            k[sleep_ctrl_pkg::WAKE_LCD] = 1'b1;
         end
         if (m == sleep_ctrl_pkg::MODE_ADC_QUIET) begin
            k[sleep_ctrl_pkg::WAKE_ADC_DONE] = 1'b1;
            k[sleep_ctrl_pkg::WAKE_STORE_READY] = 1'b1;
         end
      end
      return k;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Reset request pin synchroniser
   logic rr_meta;
   logic rr_sync;

   always_ff @(posedge clk) begin
      if (rst) begin
         rr_meta <= 1'b0;
         rr_sync <= 1'b0;
      end else if (ce) begin
         rr_meta <= reset_request;
         rr_sync <= rr_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   logic ap_valid;
   logic ap_write;
   logic ap_hit;
   logic [7:0] ap_addr;
   logic wr_go;
   logic [31:0] rd_word;
   logic sleep_allow;
   logic [2:0] mode_sel;
   logic bo_sleep_off;
   logic [2:0] bo_window;
   logic cmp_off;
   logic adc_enable;
   logic lcd_async;
   logic tmr_async;
   sleep_ctrl_pkg::state_type state;
   sleep_ctrl_pkg::state_type next_state;

   always_ff @(posedge clk) begin
      if (rst) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_hit <= 1'b0;
         ap_addr <= 8'h00;
      end else if (ce) begin
         ap_valid <= hsel && htrans[1] && hready;
         ap_write <= hwrite;
         ap_hit <= haddr[31:8] == 24'h000000 && hsize == 3'h2;
         ap_addr <= haddr[7:0];
      end
   end

   assign wr_go = ap_valid && ap_write && ap_hit;

   always_comb begin
      rd_word = 32'h00000000;
      if (haddr[31:8] != 24'h000000) begin
         rd_word = 32'h00000000;
      end else if (haddr[7:0] == sleep_ctrl_pkg::ADDR_SLEEP_CTRL) begin
         rd_word[sleep_ctrl_pkg::SLEEP_ALLOW_POS] = sleep_allow;
         rd_word[sleep_ctrl_pkg::MODE_SEL_LSB +: 3] = mode_sel;
      end else if (haddr[7:0] == sleep_ctrl_pkg::ADDR_MCU_CTRL) begin
         rd_word[sleep_ctrl_pkg::BO_SLEEP_OFF_POS] = bo_sleep_off;
         rd_word[sleep_ctrl_pkg::BO_CHANGE_EN_POS] = bo_window != 3'h0;
      end else if (haddr[7:0] == sleep_ctrl_pkg::ADDR_CMP_CTRL) begin
         rd_word[sleep_ctrl_pkg::CMP_OFF_POS] = cmp_off;
      end else if (haddr[7:0] == sleep_ctrl_pkg::ADDR_CONFIG) begin
         rd_word[sleep_ctrl_pkg::CFG_ADC_EN_POS] = adc_enable;
         rd_word[sleep_ctrl_pkg::CFG_LCD_ASYNC_POS] = lcd_async;
         rd_word[sleep_ctrl_pkg::CFG_TMR_ASYNC_POS] = tmr_async;
      end else if (haddr[7:0] == sleep_ctrl_pkg::ADDR_STATUS) begin
         rd_word[11:0] = {state, core_hold, brownout_en, clk_cpu_en, clk_flash_en, clk_io_en,
            clk_adc_en, clk_async_en, main_osc_en, timer_osc_en, comparator_power};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (hsel && htrans[1] && hready && !hwrite) begin
            hrdata <= rd_word;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge clk) begin
      if (rst) begin
         sleep_allow <= 1'b0;
         mode_sel <= sleep_ctrl_pkg::MODE_SEL_RESET;
         cmp_off <= 1'b0;
         adc_enable <= 1'b0;
         lcd_async <= 1'b0;
         tmr_async <= 1'b0;
      end else if (ce && wr_go) begin
         if (ap_addr == sleep_ctrl_pkg::ADDR_SLEEP_CTRL) begin
            sleep_allow <= hwdata[sleep_ctrl_pkg::SLEEP_ALLOW_POS];
            mode_sel <= hwdata[sleep_ctrl_pkg::MODE_SEL_LSB +: 3];
         end else if (ap_addr == sleep_ctrl_pkg::ADDR_CMP_CTRL) begin
            cmp_off <= hwdata[sleep_ctrl_pkg::CMP_OFF_POS];
         end else if (ap_addr == sleep_ctrl_pkg::ADDR_CONFIG) begin
            adc_enable <= hwdata[sleep_ctrl_pkg::CFG_ADC_EN_POS];
            lcd_async <= hwdata[sleep_ctrl_pkg::CFG_LCD_ASYNC_POS];
            tmr_async <= hwdata[sleep_ctrl_pkg::CFG_TMR_ASYNC_POS];
         end
      end
   end

   // Timed sequence guards the sleep-off bit against stray writes
   logic mcu_wr;
   assign mcu_wr = wr_go && ap_addr == sleep_ctrl_pkg::ADDR_MCU_CTRL;

   always_ff @(posedge clk) begin
      if (rst) begin
         bo_sleep_off <= sleep_ctrl_pkg::BO_SLEEP_OFF_RESET;
         bo_window <= 3'h0;
      end else if (ce) begin
         if (mcu_wr && hwdata[sleep_ctrl_pkg::BO_CHANGE_EN_POS] &&
             hwdata[sleep_ctrl_pkg::BO_SLEEP_OFF_POS]) begin
            bo_window <= 3'(sleep_ctrl_pkg::BO_CHANGE_WINDOW);
         end else if (mcu_wr && bo_window != 3'h0) begin
            bo_sleep_off <= hwdata[sleep_ctrl_pkg::BO_SLEEP_OFF_POS];
            bo_window <= 3'h0;
         end else if (bo_window != 3'h0) begin
            bo_window <= bo_window - 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sleep sequencer
   logic [2:0] mode_q;
   logic [2:0] next_mode;
   logic bo_cut;
   logic next_bo_cut;
   logic by_reset;
   logic [1:0] hold_cnt;
   logic enter;
   logic wake_hit;
   logic tmr_load;
   logic tmr_done;
   logic [DW-1:0] delay;

   assign enter = state == sleep_ctrl_pkg::ST_RUN && halt_instr && sleep_allow && mode_valid(mode_sel);
   assign wake_hit = |(wake_src & wake_mask(mode_q, cmp_off));
   assign tmr_load = state == sleep_ctrl_pkg::ST_SLEEP && next_state == sleep_ctrl_pkg::ST_WAKE;

   always_comb begin
      next_state = state;
      case (state)
         sleep_ctrl_pkg::ST_RUN: begin
            if (enter) begin
               next_state = sleep_ctrl_pkg::ST_SLEEP;
            end
         end
         sleep_ctrl_pkg::ST_SLEEP: begin
            if (rr_sync || wake_hit) begin
               next_state = sleep_ctrl_pkg::ST_WAKE;
            end
         end
         sleep_ctrl_pkg::ST_WAKE: begin
            if (tmr_done) begin
               next_state = by_reset ? sleep_ctrl_pkg::ST_RUN : sleep_ctrl_pkg::ST_HOLD;
            end
         end
         sleep_ctrl_pkg::ST_HOLD: begin
            if (hold_cnt == 2'h0) begin
               next_state = sleep_ctrl_pkg::ST_RUN;
            end
         end
         default: next_state = sleep_ctrl_pkg::ST_RUN;
      endcase
   end

   assign next_mode = enter ? mode_sel : mode_q;
   assign next_bo_cut = enter ? (bo_sleep_off && deep_mode(mode_sel)) :
      (next_state == sleep_ctrl_pkg::ST_SLEEP && bo_cut);

   always_comb begin
      delay = (mode_q == sleep_ctrl_pkg::MODE_STANDBY) ? DW'(sleep_ctrl_pkg::STANDBY_WAKE_CYCLES) :
         DW'(STARTUP_CYCLES);
      if (bo_cut && delay < DW'(sleep_ctrl_pkg::BO_WAKE_CYCLES)) begin
         delay = DW'(sleep_ctrl_pkg::BO_WAKE_CYCLES);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= sleep_ctrl_pkg::ST_RUN;
         mode_q <= sleep_ctrl_pkg::MODE_SEL_RESET;
         bo_cut <= 1'b0;
         by_reset <= 1'b0;
         hold_cnt <= 2'h0;
      end else if (ce) begin
         state <= next_state;
         mode_q <= next_mode;
         bo_cut <= next_bo_cut;
         if (state == sleep_ctrl_pkg::ST_SLEEP) begin
            by_reset <= rr_sync;
         end
         if (next_state == sleep_ctrl_pkg::ST_HOLD && state != sleep_ctrl_pkg::ST_HOLD) begin
            hold_cnt <= 2'(sleep_ctrl_pkg::IRQ_HOLD_CYCLES - 1);
         end else if (hold_cnt != 2'h0) begin
            hold_cnt <= hold_cnt - 2'h1;
         end
      end
   end

   wake_timer #(
      .WIDTH(DW)
   ) u_wake_timer (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .load(tmr_load),
      .value(delay - 1'b1),
      .done(tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Registered domain controls, driven from the next state
   logic awake;
   logic m_idle;
   logic m_adcq;
   logic m_save;
   logic m_stby;

   assign awake = next_state == sleep_ctrl_pkg::ST_RUN || next_state == sleep_ctrl_pkg::ST_HOLD;
   assign m_idle = next_mode == sleep_ctrl_pkg::MODE_IDLE;
   assign m_adcq = next_mode == sleep_ctrl_pkg::MODE_ADC_QUIET;
   assign m_save = next_mode == sleep_ctrl_pkg::MODE_POWER_SAVE;
   assign m_stby = next_mode == sleep_ctrl_pkg::MODE_STANDBY;

   always_ff @(posedge clk) begin
      if (rst) begin
         clk_cpu_en <= 1'b1;
         clk_flash_en <= 1'b1;
         clk_io_en <= 1'b1;
         clk_adc_en <= 1'b1;
         clk_async_en <= 1'b1;
         main_osc_en <= 1'b1;
         timer_osc_en <= 1'b0;
         comparator_power <= 1'b1;
         brownout_en <= 1'b1;
         core_hold <= 1'b0;
      end else if (ce) begin
         clk_cpu_en <= awake;
         clk_flash_en <= awake;
         clk_io_en <= awake || m_idle;
         clk_adc_en <= awake || m_idle || m_adcq;
         clk_async_en <= awake || m_idle || m_adcq || m_save;
         main_osc_en <= awake || m_idle || m_adcq || m_stby;
         timer_osc_en <= (lcd_async || tmr_async) && (awake || m_idle || m_adcq || m_save);
         comparator_power <= !cmp_off && (awake || m_idle || m_adcq);
         brownout_en <= !next_bo_cut;
         core_hold <= next_state != sleep_ctrl_pkg::ST_RUN;
      end
   end

   // Interrupt wake only holds the core, so its registers keep their contents
   always_ff @(posedge clk) begin
      if (rst) begin
         adc_start <= 1'b0;
         resume_from_reset <= 1'b0;
      end else if (ce) begin
         adc_start <= enter && adc_enable && (mode_sel == sleep_ctrl_pkg::MODE_IDLE ||
            mode_sel == sleep_ctrl_pkg::MODE_ADC_QUIET);
         resume_from_reset <= state == sleep_ctrl_pkg::ST_WAKE && tmr_done && by_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sleep_gate_a: assert property (ce && state == sleep_ctrl_pkg::ST_RUN && halt_instr &&
      !sleep_allow |=> state == sleep_ctrl_pkg::ST_RUN) else $error("halt without allow slept");
   bad_mode_a: assert property (ce && halt_instr && !mode_valid(mode_sel) &&
      state == sleep_ctrl_pkg::ST_RUN |=> core_hold == 1'b0) else $error("undefined mode slept");
   idle_clocks_a: assert property (state == sleep_ctrl_pkg::ST_SLEEP && mode_q == sleep_ctrl_pkg::MODE_IDLE
      |-> !clk_cpu_en && !clk_flash_en && clk_io_en && clk_adc_en) else $error("idle clock gating wrong");
   quiet_clocks_a: assert property (state == sleep_ctrl_pkg::ST_SLEEP &&
      mode_q == sleep_ctrl_pkg::MODE_ADC_QUIET |-> !clk_io_en && clk_adc_en && clk_async_en)
      else $error("adc quiet gating wrong");
   adc_start_a: assert property (ce && enter && adc_enable && mode_sel == sleep_ctrl_pkg::MODE_IDLE
      |=> adc_start ##1 !adc_start || !ce) else $error("adc start missing");
   irq0_edge_a: assert property (ce && state == sleep_ctrl_pkg::ST_SLEEP && !rr_sync &&
      mode_q != sleep_ctrl_pkg::MODE_IDLE && wake_src == WAKE_W'(1 << sleep_ctrl_pkg::WAKE_IRQ0_EDGE)
      |=> state == sleep_ctrl_pkg::ST_SLEEP) else $error("edge irq woke deep sleep");
   hold_exit_a: assert property (ce && state == sleep_ctrl_pkg::ST_HOLD && hold_cnt == 2'h0
      |=> state == sleep_ctrl_pkg::ST_RUN && !core_hold) else $error("hold did not end");
   hold_entry_a: assert property (ce && state == sleep_ctrl_pkg::ST_WAKE && tmr_done && !by_reset
      |=> state == sleep_ctrl_pkg::ST_HOLD && hold_cnt == 2'h3 && clk_cpu_en && core_hold)
      else $error("hold entry wrong");
   reset_wake_a: assert property (ce && state == sleep_ctrl_pkg::ST_SLEEP && rr_sync
      |=> state == sleep_ctrl_pkg::ST_WAKE && by_reset) else $error("reset did not wake");
   bo_lock_a: assert property (ce && mcu_wr && bo_window == 3'h0 &&
      !hwdata[sleep_ctrl_pkg::BO_CHANGE_EN_POS] |=> $stable(bo_sleep_off)) else $error("unguarded write");
   bo_cut_a: assert property (state == sleep_ctrl_pkg::ST_SLEEP && bo_cut |-> !brownout_en &&
      deep_mode(mode_q)) else $error("detector cut wrong");
   bo_wake_a: assert property (state != sleep_ctrl_pkg::ST_SLEEP |-> brownout_en)
      else $error("detector not restored");
   standby_fast_a: assert property (ce && tmr_load && mode_q == sleep_ctrl_pkg::MODE_STANDBY &&
      !bo_cut |-> delay == DW'(6)) else $error("standby delay wrong");

   idle_entry_c: cover property (enter && mode_sel == sleep_ctrl_pkg::MODE_IDLE);
   irq_resume_c: cover property (state == sleep_ctrl_pkg::ST_HOLD ##1 state == sleep_ctrl_pkg::ST_RUN);
   reset_resume_c: cover property (resume_from_reset);
   bo_long_wake_c: cover property (tmr_load && bo_cut);
endmodule
`default_nettype wire

// [pkg/sleep_ctrl_pkg.sv]
// Constants, states and register map of the sleep mode controller
package sleep_ctrl_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_SLEEP_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MCU_CTRL = 8'h04;
   localparam logic [7:0] ADDR_CMP_CTRL = 8'h08;
   localparam logic [7:0] ADDR_CONFIG = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   // Field positions
   localparam int SLEEP_ALLOW_POS = 0;
   localparam int MODE_SEL_LSB = 1;
   localparam int BO_CHANGE_EN_POS = 5;
   localparam int BO_SLEEP_OFF_POS = 6;
   localparam int CMP_OFF_POS = 7;
   localparam int CFG_ADC_EN_POS = 0;
   localparam int CFG_LCD_ASYNC_POS = 1;
   localparam int CFG_TMR_ASYNC_POS = 2;
   // Values after reset
   localparam logic [2:0] MODE_SEL_RESET = 3'h0;
   localparam logic BO_SLEEP_OFF_RESET = 1'b0;
   // Sleep mode codes
   localparam logic [2:0] MODE_IDLE = 3'h0;
   localparam logic [2:0] MODE_ADC_QUIET = 3'h1;
   localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
   localparam logic [2:0] MODE_POWER_SAVE = 3'h3;
   localparam logic [2:0] MODE_STANDBY = 3'h6;
   // Wake source indices
   localparam int WAKE_IRQ0_LEVEL = 0;
   localparam int WAKE_IRQ0_EDGE = 1;
   localparam int WAKE_PIN_CHANGE = 2;
   localparam int WAKE_SERIAL_START = 3;
   localparam int WAKE_ASYNC_TIMER = 4;
   localparam int WAKE_STORE_READY = 5;
   localparam int WAKE_ADC_DONE = 6;
   localparam int WAKE_LCD = 7;
   localparam int WAKE_WATCHDOG = 8;
   localparam int WAKE_COMPARATOR = 9;
   localparam int WAKE_OTHER_IO = 10;
   localparam int WAKE_COUNT = 11;
   // Timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int BO_WAKE_NS = 60000;
   localparam int BO_WAKE_CYCLES = (BO_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STANDBY_WAKE_CYCLES = 6;
   localparam int IRQ_HOLD_CYCLES = 4;
   localparam int BO_CHANGE_WINDOW = 4;
   localparam int DELAY_W = 12;
   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE, ST_HOLD} state_type;
endpackage

// [rtl/wake_timer.sv]
// Down counter that times the wake-up delay
`timescale 1ns/100ps
`default_nettype none
module wake_timer #(
   parameter int WIDTH = 12
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic load,
   input wire logic [WIDTH-1:0] value,
   output logic done
);
   logic [WIDTH-1:0] count;

   generate
      if (WIDTH < 2) begin : g_bad_width
         $error("wake_timer WIDTH too small");
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         count <= '0;
      end else if (ce) begin
         if (load) begin
            count <= value;
         end else if (count != '0) begin
            count <= count - 1'b1;
         end
      end
   end

   assign done = (count == '0);
endmodule
`default_nettype wire

// [dv/core_model.sv]
// Behavioural core and wake-source side facing the sleep controller
`timescale 1ns/100ps
`default_nettype none
module core_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic core_hold,
   input wire logic halt_req,
   input wire logic [sleep_ctrl_pkg::WAKE_COUNT-1:0] wake_req,
   input wire logic rst_req,
   output logic halt_instr,
   output logic [sleep_ctrl_pkg::WAKE_COUNT-1:0] wake_src,
   output logic reset_request
);
   always_ff @(posedge clk) begin
      if (rst) begin
         halt_instr <= 1'b0;
         wake_src <= '0;
         reset_request <= 1'b0;
      end else begin
         // A held core executes nothing, so no halt while gated
         halt_instr <= halt_req & ~core_hold;
         wake_src <= wake_req;
         reset_request <= rst_req;
      end
   end
endmodule
`default_nettype wire

// [dv/sleep_mode_controller_bench.sv]
// Self-checking bench for the sleep mode controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module sleep_mode_controller_bench;
   typedef struct packed {logic [2:0] mode; logic allow; logic [3:0] bad; logic [3:0] good;
      logic sleeps; logic [6:0] clks; logic adc;} row_type;
   // Clock order: cpu, flash, io, adc, async, main osc, timer osc; bad 4'hF = none
   row_type rows [7] = '{'{3'h0, 1'b1, 4'hF, 4'hA, 1'b1, 7'h1F, 1'b1}, '{3'h1, 1'b1, 4'hA, 4'h6, 1'b1, 7'h0F, 1'b1},
      '{3'h2, 1'b1, 4'h1, 4'h0, 1'b1, 7'h00, 1'b0}, '{3'h3, 1'b1, 4'h5, 4'h4, 1'b1, 7'h05, 1'b0},
      '{3'h6, 1'b1, 4'h7, 4'h8, 1'b1, 7'h02, 1'b0}, '{3'h4, 1'b1, 4'hF, 4'hF, 1'b0, 7'h7F, 1'b0},
      '{3'h0, 1'b0, 4'hF, 4'hF, 1'b0, 7'h7F, 1'b0}};
   logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, halt_req = 1'b0, rst_req = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [10:0] wake_req = 11'h0, wake_src;
   logic hreadyout, hresp, halt_instr, reset_request, core_hold, resume_from_reset, brownout_en;
   logic clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, clk_async_en, main_osc_en, timer_osc_en;
   logic comparator_power, adc_start;
   logic [6:0] clks;
   int err_total = 0, n_checks = 0, adc_cnt = 0, a, n, m;
   assign clks = {clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, clk_async_en, main_osc_en, timer_osc_en};
   always #10 clk = ~clk;
   always @(posedge clk) if (adc_start === 1'b1) adc_cnt++;
   sleep_mode_controller #(.STARTUP_CYCLES(2)) dut (.clk(clk), .rst(rst), .ce(1'b1), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .halt_instr(halt_instr), .wake_src(wake_src),
      .reset_request(reset_request), .core_hold(core_hold), .resume_from_reset(resume_from_reset),
      .clk_cpu_en(clk_cpu_en), .clk_flash_en(clk_flash_en), .clk_io_en(clk_io_en), .clk_adc_en(clk_adc_en),
      .clk_async_en(clk_async_en), .main_osc_en(main_osc_en), .timer_osc_en(timer_osc_en),
      .brownout_en(brownout_en), .comparator_power(comparator_power), .adc_start(adc_start));
   core_model partner (.clk(clk), .rst(rst), .core_hold(core_hold), .halt_req(halt_req), .wake_req(wake_req),
      .rst_req(rst_req), .halt_instr(halt_instr), .wake_src(wake_src), .reset_request(reset_request));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      @(posedge clk);
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, ad};
      do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
      q = hrdata;
   endtask
   task automatic sleep_go(input logic [2:0] md, input logic al);
      bus(1'b1, sleep_ctrl_pkg::ADDR_SLEEP_CTRL, {28'h0, md, al}, rd);
      halt_req <= 1'b1;
      @(posedge clk);
      halt_req <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   // Counts cycles to clock restart, then cycles of the extra hold
   task automatic wake_up(input logic [10:0] src);
      wake_req <= src;
      n = 0;
      m = 0;
      while (clk_cpu_en !== 1'b1 && n < 5000) begin tick(); n++; end
      while (core_hold === 1'b1 && m < 20) begin tick(); m++; end
      wake_req <= 11'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, sleep_ctrl_pkg::ADDR_STATUS, 32'h0, rd);
      `CHK("status", 32'h1FD, rd)
      bus(1'b0, 8'h20, 32'h0, rd);
      `CHK("unmapped", 32'h0, rd)
      bus(1'b1, sleep_ctrl_pkg::ADDR_CMP_CTRL, 32'h80, rd);
      tick();
      `CHK("cmp power", 1'b0, comparator_power)
      bus(1'b1, sleep_ctrl_pkg::ADDR_CMP_CTRL, 32'h0, rd);
      bus(1'b1, sleep_ctrl_pkg::ADDR_CONFIG, 32'h3, rd);
      foreach (rows[i]) begin
         a = adc_cnt;
         // Standby row assumes a crystal clock source is fitted
         sleep_go(rows[i].mode, rows[i].allow);
         `CHK("clocks", rows[i].clks, clks)
         `CHK("hold", rows[i].sleeps, core_hold)
         `CHK("adc start", rows[i].adc, 1'(adc_cnt - a))
         `CHK("detector", 1'b1, brownout_en)
         if (rows[i].sleeps) begin
            if (rows[i].bad != 4'hF) begin
               wake_req <= 11'h1 << rows[i].bad;
               repeat (8) tick();
               `CHK("masked", 1'b1, clk_cpu_en === 1'b0)
            end
            wake_up(11'h1 << rows[i].good);
            // Two cycles of partner and detection latency before the six
            if (rows[i].mode == sleep_ctrl_pkg::MODE_STANDBY) `CHK("standby", 1'b1, n <= 9)
            `CHK("irq hold", 4, m)
            tick();
         end
      end
      bus(1'b1, sleep_ctrl_pkg::ADDR_MCU_CTRL, 32'h40, rd);
      bus(1'b0, sleep_ctrl_pkg::ADDR_MCU_CTRL, 32'h0, rd);
      `CHK("brownout_sleep_off locked", 1'b0, rd[6])
      bus(1'b1, sleep_ctrl_pkg::ADDR_MCU_CTRL, 32'h60, rd);
      bus(1'b1, sleep_ctrl_pkg::ADDR_MCU_CTRL, 32'h40, rd);
      bus(1'b0, sleep_ctrl_pkg::ADDR_MCU_CTRL, 32'h0, rd);
      `CHK("brownout_sleep_off set", 1'b1, rd[6])
      sleep_go(sleep_ctrl_pkg::MODE_POWER_DOWN, 1'b1);
      `CHK("detector off", 1'b0, brownout_en)
      wake_up(11'h1);
      `CHK("detector on", 1'b1, brownout_en)
      `CHK("long wake", 1'b1, n >= 3000)
      tick();
      sleep_go(sleep_ctrl_pkg::MODE_POWER_DOWN, 1'b1);
      rst_req <= 1'b1;
      n = 0;
      while (resume_from_reset !== 1'b1 && n < 5000) begin tick(); n++; end
      rst_req <= 1'b0;
      `CHK("reset vector", 1'b1, resume_from_reset)
      `CHK("reset run", 1'b0, core_hold)
      final_report();
   end
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      final_report();
   end
endmodule
`default_nettype wire
